//--- cmcf_pkg.sv
// Package: register map, mode codes and field layouts for the CAN mode controller
package cmcf_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_CONTROL = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h1;
    localparam logic [3:0] OFF_FUNC_MODE = 4'h2;
    localparam logic [3:0] OFF_BIT_TIMING = 4'h3;
    localparam logic [3:0] OFF_ERR_COUNT = 4'h4;
    localparam logic [3:0] OFF_RX_MATCH = 4'h5;
    localparam logic [3:0] OFF_LINK_BASE = 4'h8;
    localparam int REQ_MODE_MSB = 7;
    localparam int REQ_MODE_LSB = 5;
    localparam int CFG_REQ_BIT = 7;
    localparam int NUM_LINK_REGS = 8;
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_SLEEP = 3'h1;
    localparam logic [2:0] MODE_LOOPBACK = 3'h2;
    localparam logic [2:0] MODE_LISTEN = 3'h3;
    localparam logic [2:0] MODE_CONFIG = 3'h4;
    localparam logic [2:0] MODE_ERR_RECOG = 3'h7;
    localparam logic [2:0] RESET_MODE = 3'h4;
    localparam logic [1:0] RXM_ERR_RECOG = 2'h3;
    localparam logic [3:0] PTR_LAST_VALID = 4'h7;
    localparam logic [3:0] PTR_PROG_BASE = 4'h2;
    localparam logic [7:0] LINK_RST_0 = 8'h00;
    localparam logic [7:0] LINK_RST_1 = 8'h11;
    localparam logic [7:0] LINK_RST_2 = 8'h11;
    localparam logic [7:0] LINK_RST_OTHER = 8'h00;
    localparam logic [1:0] FUNC_MODE_LEGACY = 2'h0;
    localparam int IDLE_RECESSIVE_BITS = 11;
    localparam logic [3:0] IDLE_BITS_CNT = 4'(IDLE_RECESSIVE_BITS);
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cmcf_bus_t;
    typedef struct packed {
        logic hit;
        logic dedicated;
        logic [2:0] buffer;
    } cmcf_route_t;
endpackage

//--- cmcf_top.sv
// CAN operating-mode controller, configuration lock and filter-to-buffer map
//
// Overview of operation
// - Pointer nibble selects dedicated or programmable buffer
// - Two filter nibbles per map register, odd high
// - Map registers usable only in modes 1 to 3
// - Requested-mode field in control bits 7:5
// - Error recognition entered via receive-match bits
// - Current-mode field reports the entered mode
// - Mode switch waits for pending transmissions
// - Config requested by top bit, status confirms; code takes only 100 as config, 101 to 111 as requested modes 5 to 7
// - All-zero request leaves config, goes normal unless receive-match bits select error recognition
// - Config registers write-protected while online
// - Config entry refused during transmit or receive
// - Lock covers function mode, timing, receive-match and map groups
// - Config mode: no traffic, counters cleared
// - Config mode opens restricted registers to writes
// - Config mode returns bus pins to GPIO
// - Sleep request waits eleven recessive bits when active
// - Sleep entry reported as current mode 001
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cmcf_top #(
    parameter int NUM_FILTERS = 16
) (
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    input wire logic [3:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic TX_PENDING_IN,
    input wire logic RX_BUSY_IN,
    input wire logic BIT_TICK_IN,
    input wire logic BUS_RECESSIVE_IN,
    input wire logic ERR_INC_TX_IN,
    input wire logic ERR_INC_RX_IN,
    input wire logic MATCH_VALID_IN,
    input wire logic [3:0] MATCH_FILTER_IN,
    output logic [7:0] RDATA_OUT,
    output logic [2:0] MODE_OUT,
    output logic TRAFFIC_EN_OUT,
    output logic TX_EN_OUT,
    output logic PINS_GPIO_OUT,
    output logic ROUTE_VALID_OUT,
    output logic ROUTE_DEDICATED_OUT,
    output logic [2:0] ROUTE_BUFFER_OUT
);
    initial begin
        if (NUM_FILTERS != 2 * cmcf_pkg::NUM_LINK_REGS) begin
            $error("NUM_FILTERS must equal twice the map register count");
        end
    end

    typedef enum logic [1:0] {CMCF_IDLE, CMCF_WAIT_TX, CMCF_WAIT_IDLE} cmcf_sw_t;

    cmcf_pkg::cmcf_bus_t bus;
    assign bus = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};

    logic [2:0] req_q;
    logic [2:0] mode_q;
    logic [1:0] func_q;
    logic [7:0] timing_q;
    logic [1:0] rxm_q;
    logic [7:0] tec_q;
    logic [7:0] rec_q;
    logic [3:0] idle_cnt_q;
    logic [7:0] link_q [cmcf_pkg::NUM_LINK_REGS];
    cmcf_sw_t sw_q;
    logic [2:0] target;
    logic in_cfg;
    logic map_on;
    logic is_link;
    logic [2:0] link_idx;
    logic active;
    cmcf_pkg::cmcf_route_t route;

    // Decode of a pointer nibble into buffer selection
    function automatic cmcf_pkg::cmcf_route_t ptr_decode(input logic [3:0] p);
        cmcf_pkg::cmcf_route_t r;
        r.hit = (p <= cmcf_pkg::PTR_LAST_VALID);
        r.dedicated = (p < cmcf_pkg::PTR_PROG_BASE);
        r.buffer = r.dedicated ? 3'(p) : 3'(p - cmcf_pkg::PTR_PROG_BASE);
        return r;
    endfunction

    function automatic logic [7:0] link_reset(input int i);
        case (i)
            0: return cmcf_pkg::LINK_RST_0;
            1: return cmcf_pkg::LINK_RST_1;
            2: return cmcf_pkg::LINK_RST_2;
            default: return cmcf_pkg::LINK_RST_OTHER;
        endcase
    endfunction

    assign in_cfg = (mode_q == cmcf_pkg::MODE_CONFIG);
    // map only in modes 1 to 3
    assign map_on = (func_q != cmcf_pkg::FUNC_MODE_LEGACY);
    assign is_link = bus.addr[3];
    assign link_idx = bus.addr[2:0];
    assign active = TX_PENDING_IN || RX_BUSY_IN;
    // receive-match bits override requested field for error recognition
    assign target = (rxm_q == cmcf_pkg::RXM_ERR_RECOG && req_q != cmcf_pkg::MODE_CONFIG
                     && req_q != cmcf_pkg::MODE_SLEEP) ? cmcf_pkg::MODE_ERR_RECOG : req_q;

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            req_q <= cmcf_pkg::RESET_MODE;
        end else if (bus.wr && bus.addr == cmcf_pkg::OFF_CONTROL) begin
            req_q <= bus.wdata[cmcf_pkg::REQ_MODE_MSB:cmcf_pkg::REQ_MODE_LSB];
        end
    end

    // switch sequencer, waits for transmissions, then for bus idle before config or sleep
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            mode_q <= cmcf_pkg::RESET_MODE;
            sw_q <= CMCF_IDLE;
            idle_cnt_q <= 4'h0;
        end else begin
            case (sw_q)
                CMCF_IDLE: begin
                    if (target != mode_q) begin
                        sw_q <= CMCF_WAIT_TX;
                    end
                end
                CMCF_WAIT_TX: begin
                    if (target == mode_q) begin
                        sw_q <= CMCF_IDLE;
                    end else if (!TX_PENDING_IN) begin
                        // config and sleep wait for a quiet bus
                        if ((target == cmcf_pkg::MODE_CONFIG || target == cmcf_pkg::MODE_SLEEP) && active) begin
                            sw_q <= CMCF_WAIT_IDLE;
                            idle_cnt_q <= 4'h0;
                        end else begin
                            // current mode changes on the switch cycle
                            mode_q <= target;
                            sw_q <= CMCF_IDLE;
                        end
                    end
                end
                CMCF_WAIT_IDLE: begin
                    // count recessive bit times as idle bus
                    if (target == mode_q) begin
                        sw_q <= CMCF_IDLE;
                    end else if (BIT_TICK_IN) begin
                        if (!BUS_RECESSIVE_IN || active) begin
                            idle_cnt_q <= 4'h0;
                        end else if (idle_cnt_q == cmcf_pkg::IDLE_BITS_CNT - 4'h1) begin
                            // sleep and config reported on entry
                            mode_q <= target;
                            sw_q <= CMCF_IDLE;
                            idle_cnt_q <= 4'h0;
                        end else begin
                            idle_cnt_q <= idle_cnt_q + 4'h1;
                        end
                    end
                end
                default: sw_q <= CMCF_IDLE;
            endcase
        end
    end

    // locked groups accept writes only in config mode
    // function mode, timing, receive-match and map are locked
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            func_q <= cmcf_pkg::FUNC_MODE_LEGACY;
            timing_q <= 8'h00;
            rxm_q <= 2'h0;
        end else if (bus.wr && in_cfg) begin
            if (bus.addr == cmcf_pkg::OFF_FUNC_MODE) begin
                func_q <= bus.wdata[1:0];
            end
            if (bus.addr == cmcf_pkg::OFF_BIT_TIMING) begin
                timing_q <= bus.wdata;
            end
            if (bus.addr == cmcf_pkg::OFF_RX_MATCH) begin
                rxm_q <= bus.wdata[1:0];
            end
        end
    end

    // odd filter high nibble, even filter low nibble
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            for (int i = 0; i < cmcf_pkg::NUM_LINK_REGS; i++) begin
                link_q[i] <= link_reset(i);
            end
        end else if (bus.wr && is_link && in_cfg && map_on) begin
            link_q[link_idx] <= bus.wdata;
        end
    end

    // error counters cleared in config mode
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN || in_cfg) begin
            tec_q <= 8'h00;
            rec_q <= 8'h00;
        end else begin
            if (ERR_INC_TX_IN && tec_q != 8'hFF) begin
                tec_q <= tec_q + 8'h01;
            end
            if (ERR_INC_RX_IN && rec_q != 8'hFF) begin
                rec_q <= rec_q + 8'h01;
            end
        end
    end

    // read path shows the entered mode
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            RDATA_OUT <= 8'h00;
        end else if (bus.rd) begin
            if (is_link) begin
                RDATA_OUT <= map_on ? link_q[link_idx] : 8'h00;
            end else begin
                case (bus.addr)
                    cmcf_pkg::OFF_CONTROL: RDATA_OUT <= {req_q, 5'h00};
                    cmcf_pkg::OFF_STATUS: RDATA_OUT <= {mode_q, 5'h00};
                    cmcf_pkg::OFF_FUNC_MODE: RDATA_OUT <= {6'h00, func_q};
                    cmcf_pkg::OFF_BIT_TIMING: RDATA_OUT <= timing_q;
                    cmcf_pkg::OFF_ERR_COUNT: RDATA_OUT <= tec_q | rec_q;
                    cmcf_pkg::OFF_RX_MATCH: RDATA_OUT <= {6'h00, rxm_q};
                    default: RDATA_OUT <= 8'h00;
                endcase
            end
        end else begin
            RDATA_OUT <= 8'h00;
        end
    end

    // route a filter match to its buffer
    assign route = ptr_decode(MATCH_FILTER_IN[0] ? link_q[MATCH_FILTER_IN[3:1]][7:4]
                                                 : link_q[MATCH_FILTER_IN[3:1]][3:0]);

    // pins and traffic follow the entered mode
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            MODE_OUT <= cmcf_pkg::RESET_MODE;
            TRAFFIC_EN_OUT <= 1'b0;
            TX_EN_OUT <= 1'b0;
            PINS_GPIO_OUT <= 1'b1;
            ROUTE_VALID_OUT <= 1'b0;
            ROUTE_DEDICATED_OUT <= 1'b0;
            ROUTE_BUFFER_OUT <= 3'h0;
        end else begin
            MODE_OUT <= mode_q;
            TRAFFIC_EN_OUT <= !in_cfg && mode_q != cmcf_pkg::MODE_SLEEP;
            TX_EN_OUT <= mode_q == cmcf_pkg::MODE_NORMAL || mode_q == cmcf_pkg::MODE_LOOPBACK;
            PINS_GPIO_OUT <= in_cfg;
            ROUTE_VALID_OUT <= MATCH_VALID_IN && map_on && !in_cfg && route.hit;
            ROUTE_DEDICATED_OUT <= route.dedicated;
            ROUTE_BUFFER_OUT <= route.buffer;
        end
    end

    // Assertions
    // locked timing register holds outside config
    chk_lock_holds: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        !in_cfg |=> $stable(timing_q)) else $error("timing changed while online");
    // no switch while a transmission is pending
    chk_wait_tx: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        TX_PENDING_IN && sw_q != CMCF_WAIT_IDLE |=> $stable(mode_q)) else $error("mode switched during tx");
    chk_cnt_clear: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        in_cfg |=> tec_q == 8'h00 && rec_q == 8'h00) else $error("counters not cleared");
    // GPIO flag tracks config one cycle later
    chk_pins_gpio: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        in_cfg |=> PINS_GPIO_OUT) else $error("pins not released");
    chk_mode_out: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        ##1 MODE_OUT == $past(mode_q)) else $error("mode output lags");
    // zero request with quiet bus reaches normal
    chk_to_normal: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        req_q == 3'h0 && rxm_q == 2'h0 && sw_q == CMCF_IDLE && !TX_PENDING_IN [*2]
        |=> mode_q == cmcf_pkg::MODE_NORMAL) else $error("normal not entered");
    // config never entered while bus busy from direct path
    chk_cfg_refuse: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        sw_q == CMCF_WAIT_TX && target == cmcf_pkg::MODE_CONFIG && active |=> !in_cfg || $past(in_cfg))
        else $error("config entered while busy");
    chk_map_legacy: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        !map_on |=> !ROUTE_VALID_OUT) else $error("route in legacy mode");

    // Steps of a direct switch: a quiet request, then the entered mode
    sequence seq_quiet_request;
        sw_q == CMCF_WAIT_TX && target != mode_q && !TX_PENDING_IN && !active;
    endsequence
    sequence seq_switch_seen;
        mode_q == $past(target);
    endsequence
    // quiet bus switches on the next edge
    chk_quiet_switch: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        seq_quiet_request |=> seq_switch_seen) else $error("quiet switch missed");
    chk_lock_func: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        !in_cfg |=> $stable(func_q)) else $error("function mode changed while online");
    chk_lock_rxm: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        !in_cfg |=> $stable(rxm_q)) else $error("receive match changed while online");
    // map register ignores writes in legacy mode
    chk_map_lock: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        !map_on |=> $stable(link_q[0])) else $error("map written in legacy mode");
    // dominant or busy bit restarts the idle run
    chk_idle_reset: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        sw_q == CMCF_WAIT_IDLE && BIT_TICK_IN && (!BUS_RECESSIVE_IN || active) |=> idle_cnt_q == 4'h0)
        else $error("idle run not restarted");
    // no switch between bit ticks while waiting for idle
    chk_tick_gate: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        sw_q == CMCF_WAIT_IDLE && !BIT_TICK_IN |=> $stable(mode_q)) else $error("switch without bit tick");
    chk_cfg_quiet: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        in_cfg |=> !TX_EN_OUT && !TRAFFIC_EN_OUT) else $error("traffic in config mode");
    // no receive routing in config mode
    chk_route_cfg: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        in_cfg |=> !ROUTE_VALID_OUT) else $error("route in config mode");
    chk_route_reserved: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        MATCH_VALID_IN && !route.hit |=> !ROUTE_VALID_OUT) else $error("reserved pointer routed");
    chk_sleep_report: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        mode_q == cmcf_pkg::MODE_SLEEP |=> MODE_OUT == cmcf_pkg::MODE_SLEEP) else $error("sleep not reported");
    chk_sleep_traffic: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        mode_q == cmcf_pkg::MODE_SLEEP |=> !TRAFFIC_EN_OUT) else $error("traffic in sleep");
    // control write loads the requested field
    chk_req_write: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        WR_IN && ADDR_IN == cmcf_pkg::OFF_CONTROL
        |=> req_q == $past(WDATA_IN[cmcf_pkg::REQ_MODE_MSB:cmcf_pkg::REQ_MODE_LSB])) else $error("request not loaded");
    // error recognition chosen by receive-match bits
    chk_err_target: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        rxm_q == cmcf_pkg::RXM_ERR_RECOG && req_q == cmcf_pkg::MODE_NORMAL |-> target == cmcf_pkg::MODE_ERR_RECOG)
        else $error("error recognition not targeted");
    // pins belong to the bus while online
    chk_gpio_online: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        !in_cfg |=> !PINS_GPIO_OUT) else $error("pins released while online");
    // read data stands only after a read
    chk_rd_idle: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        !RD_IN |=> RDATA_OUT == 8'h00) else $error("read data without read");
endmodule
`default_nettype wire

//--- cmcf_bus_model.sv
// Far-side model: pending transmit, reception and bit timing of the CAN bus
`timescale 1ns/1ps
`default_nettype none
module cmcf_bus_model (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic hold_tx_in,
    input wire logic hold_rx_in,
    output logic tx_pending_out,
    output logic rx_busy_out,
    output logic bit_tick_out,
    output logic bus_recessive_out
);
    logic [1:0] div_q;
    logic pat_q;
    // Frames toggle the bus each bit, so only a quiet bus gives a recessive run
    assign bus_recessive_out = !rx_busy_out || pat_q;
    always_ff @(posedge clk_in) begin
        div_q <= srst_in ? 2'h0 : div_q + 2'h1;
        bit_tick_out <= !srst_in && div_q == 2'h3;
        pat_q <= srst_in ? 1'b0 : pat_q ^ (div_q == 2'h3);
    end
    always_ff @(posedge clk_in) begin
        tx_pending_out <= hold_tx_in;
        rx_busy_out <= hold_rx_in;
    end
endmodule
`default_nettype wire

//--- can_mode_control_filter_map_tb_top.sv
// Self-checking bench for the CAN mode controller and filter map
`timescale 1ns/1ps
`default_nettype none
module can_mode_control_filter_map_tb_top;
    logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, mv = 1'b0;
    logic hold_tx = 1'b0, hold_rx = 1'b0, err_tx = 1'b0, err_rx = 1'b0;
    logic [3:0] addr = 4'h0, mf = 4'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic [2:0] mode, rbuf;
    logic tx_pend, rx_busy, tick, recessive, traffic, tx_en, gpio, rvalid, rded;
    int fail_count = 0;
    int total_checks = 0;
    always #5 clk = ~clk;
    cmcf_top cmcf_top_inst (.CLK_IN(clk), .SRST_IN(srst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .TX_PENDING_IN(tx_pend), .RX_BUSY_IN(rx_busy), .BIT_TICK_IN(tick),
        .BUS_RECESSIVE_IN(recessive), .ERR_INC_TX_IN(err_tx), .ERR_INC_RX_IN(err_rx),
        .MATCH_VALID_IN(mv), .MATCH_FILTER_IN(mf), .RDATA_OUT(rdata), .MODE_OUT(mode),
        .TRAFFIC_EN_OUT(traffic), .TX_EN_OUT(tx_en), .PINS_GPIO_OUT(gpio), .ROUTE_VALID_OUT(rvalid),
        .ROUTE_DEDICATED_OUT(rded), .ROUTE_BUFFER_OUT(rbuf));
    cmcf_bus_model cmcf_bus_model_inst (.clk_in(clk), .srst_in(srst), .hold_tx_in(hold_tx),
        .hold_rx_in(hold_rx), .tx_pending_out(tx_pend), .rx_busy_out(rx_busy), .bit_tick_out(tick),
        .bus_recessive_out(recessive));
    task automatic summarize();
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("read data", exp, rdata);
        @(posedge clk);
    endtask
    // Software polls the current mode before going on; a mode that never comes ends the run
    task automatic wait_mode(input logic [2:0] m);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (mode !== m && n < 400);
        chk("current mode", {5'h0, m}, {5'h0, mode});
        if (mode !== m) begin
            summarize();
        end
        @(posedge clk);
    endtask
    task automatic route_chk(input logic [3:0] f, input logic [3:0] p);
        logic ok;
        logic [2:0] eb;
        ok = p <= 4'h7;
        eb = p < 4'h2 ? p[2:0] : p[2:0] - 3'h2;
        mf <= f;
        mv <= 1'b1;
        @(posedge clk);
        mv <= 1'b0;
        #1;
        chk("route", ok ? {3'h0, 1'b1, p < 4'h2, eb} : 8'h00, ok ? {3'h0, rvalid, rded, rbuf} : {7'h0, rvalid});
        @(posedge clk);
    endtask
    task automatic t_reset();
        #1;
        chk("reset outputs", 8'h90, {mode, gpio, traffic, tx_en, 2'h0});
        @(posedge clk);
        rd_chk(cmcf_pkg::OFF_STATUS, 8'h80);
        rd_chk(cmcf_pkg::OFF_LINK_BASE, 8'h00);
        wr_reg(cmcf_pkg::OFF_LINK_BASE, 8'h55);
        rd_chk(4'h6, 8'h00);
    endtask
    task automatic t_setup();
        wr_reg(cmcf_pkg::OFF_FUNC_MODE, 8'h01);
        wr_reg(cmcf_pkg::OFF_BIT_TIMING, 8'h5A);
        rd_chk(cmcf_pkg::OFF_BIT_TIMING, 8'h5A);
        rd_chk(cmcf_pkg::OFF_LINK_BASE, 8'h00);
        rd_chk(4'h9, 8'h11);
        wr_reg(4'h8, 8'h72);
        wr_reg(4'hB, 8'h80);
        rd_chk(4'h8, 8'h72);
        rd_chk(4'hB, 8'h80);
    endtask
    task automatic t_leave();
        hold_tx <= 1'b1;
        wr_reg(cmcf_pkg::OFF_CONTROL, 8'h00);
        repeat (20) @(posedge clk);
        #1;
        chk("mode while tx pending", 8'h04, {5'h0, mode});
        @(posedge clk);
        hold_tx <= 1'b0;
        wait_mode(cmcf_pkg::MODE_NORMAL);
        chk("online outputs", 8'h03, {5'h0, gpio, traffic, tx_en});
    endtask
    task automatic t_lock();
        wr_reg(4'h8, 8'h00);
        wr_reg(cmcf_pkg::OFF_FUNC_MODE, 8'h00);
        rd_chk(4'h8, 8'h72);
        rd_chk(cmcf_pkg::OFF_FUNC_MODE, 8'h01);
        wr_reg(cmcf_pkg::OFF_BIT_TIMING, 8'h00);
        wr_reg(cmcf_pkg::OFF_RX_MATCH, 8'h03);
        rd_chk(cmcf_pkg::OFF_BIT_TIMING, 8'h5A);
        rd_chk(cmcf_pkg::OFF_RX_MATCH, 8'h00);
    endtask
    task automatic t_routes();
        logic [3:0] ptr [8] = '{4'h2, 4'h7, 4'h1, 4'h1, 4'h1, 4'h1, 4'h0, 4'h8};
        for (int f = 0; f < 8; f++) begin
            route_chk(4'(f), ptr[f]);
        end
        route_chk(4'hF, 4'h0);
    endtask
    task automatic t_modes();
        logic [2:0] ms [3] = '{cmcf_pkg::MODE_LOOPBACK, cmcf_pkg::MODE_LISTEN, cmcf_pkg::MODE_NORMAL};
        for (int i = 0; i < 3; i++) begin
            wr_reg(cmcf_pkg::OFF_CONTROL, {ms[i], 5'h00});
            wait_mode(ms[i]);
            chk("tx enable", {7'h0, ms[i] != cmcf_pkg::MODE_LISTEN}, {7'h0, tx_en});
            rd_chk(cmcf_pkg::OFF_STATUS, {ms[i], 5'h00});
        end
    endtask
    task automatic t_sleep();
        int n;
        int k;
        n = 0;
        k = 0;
        hold_rx <= 1'b1;
        wr_reg(cmcf_pkg::OFF_CONTROL, 8'h20);
        repeat (30) @(posedge clk);
        hold_rx <= 1'b0;
        // Bounded: a bit clock that never ticks must not hang the run
        while (n < 10 && k < 400) begin
            @(posedge clk);
            #1;
            k++;
            n += int'(tick && recessive && !rx_busy);
        end
        chk("idle ticks seen", 8'h0A, 8'(n));
        if (n < 10) begin
            summarize();
        end
        chk("mode before idle run", 8'h00, {5'h0, mode});
        @(posedge clk);
        wait_mode(cmcf_pkg::MODE_SLEEP);
        chk("sleep traffic", 8'h00, {7'h0, traffic});
    endtask
    task automatic t_config();
        wr_reg(cmcf_pkg::OFF_CONTROL, 8'h00);
        wait_mode(cmcf_pkg::MODE_NORMAL);
        err_tx <= 1'b1;
        err_rx <= 1'b1;
        @(posedge clk);
        err_tx <= 1'b0;
        err_rx <= 1'b0;
        hold_rx <= 1'b1;
        rd_chk(cmcf_pkg::OFF_ERR_COUNT, 8'h01);
        wr_reg(cmcf_pkg::OFF_CONTROL, 8'h80);
        repeat (20) @(posedge clk);
        #1;
        chk("mode while receiving", 8'h00, {5'h0, mode});
        @(posedge clk);
        hold_rx <= 1'b0;
        wait_mode(cmcf_pkg::MODE_CONFIG);
        rd_chk(cmcf_pkg::OFF_ERR_COUNT, 8'h00);
        chk("config outputs", 8'h04, {5'h0, gpio, traffic, tx_en});
        wr_reg(cmcf_pkg::OFF_RX_MATCH, 8'h03);
        wr_reg(cmcf_pkg::OFF_CONTROL, 8'h00);
        wait_mode(cmcf_pkg::MODE_ERR_RECOG);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_setup();
        t_leave();
        t_lock();
        t_routes();
        t_modes();
        t_sleep();
        t_config();
        summarize();
    end
endmodule
`default_nettype wire
